// File: inc/acr_consts.svh
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// register addresses, 6-bit address field of the serial frame
`define ACR_ADDR_REV    6'h00
`define ACR_ADDR_CTRL   6'h01
`define ACR_ADDR_STAT   6'h02
`define ACR_ADDR_KEY    6'h03
`define ACR_ADDR_XL     6'h04
`define ACR_ADDR_XH     6'h05
`define ACR_ADDR_YL     6'h06
`define ACR_ADDR_YH     6'h07
`define ACR_ADDR_ZL     6'h08
`define ACR_ADDR_ZH     6'h09
`define ACR_ADDR_TL     6'h0c
`define ACR_ADDR_TH     6'h0d

// reset key sequence
`define ACR_KEY_1       8'h0c
`define ACR_KEY_2       8'h05
`define ACR_KEY_3       8'h0f

// reset values
`define ACR_BYTE_RST    8'h00
`define ACR_CNT_RST     5'h00

// frame layout: addr[15:10], write flag [9], addr parity [8], data [7:0]
`define ACR_RX_ADDR     15:10
`define ACR_RX_WR       9
`define ACR_RX_DATA     7:0
`define ACR_AB_ADDR     7:2
`define ACR_AB_WR       1
`define ACR_FRAME_BITS  5'h10
`define ACR_ADDR_LAST   5'h07
`define ACR_DATA_FIRST  5'h08
`define ACR_CNT_MAX     5'h1f
`define ACR_CNT_ONE     5'h01

// status register fields
`define ACR_ST_ANALOG_TEST_ACTIVE    2
`define ACR_ST_CSUM     1
`define ACR_ST_FRAME_ERROR_FLAG     0

// status byte sent first in every response frame
`define ACR_FR_ONE      7
`define ACR_FR_FRAME_ERROR_FLAG     2
`define ACR_FR_ST       1

// acceleration and temperature sample split
`define ACR_SMP_W       13
`define ACR_SMP_LO      6:0
`define ACR_SMP_HI      12:7
`define ACR_TEMP_LO     7:0
`define ACR_TEMP_HI     15:8

`endif

// File: inc/acr_pkg.sv
package acr_pkg;

  // progress through the three-write reset key
  typedef enum logic [2:0] {
    ACR_KEY_IDLE = 3'b001,
    ACR_KEY_GOT1 = 3'b010,
    ACR_KEY_GOT2 = 3'b100
  } acr_key_t;

endpackage

// File: hw/acr_sync.sv
`timescale 1ns/100ps
module acr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// File: hw/acr_regbank.sv
// Summary of operation
// - address 0x00 reads a fixed 8-bit revision number and cannot be written.
// - address 0x01 is the 8-bit control byte, written and read back by the host.
// - address 0x02 is read-only, bits 7:3 read zero, bit 2 shows analog test mode.
// - a failed memory checksum sets the checksum flag and the self-test bit of every response.
// - a bad frame sets the frame error flag, the next good frame clears it, and responses carry it.
// - writing 0x0c, 0x05, 0x0f in that order to address 0x03 resets the component.
// - axis low bytes carry data in bits 7:1, high bytes in bits 5:0, other bits zero, all read-only.
// - reading the x high byte latches the x low byte for the later low read.
// - reading the y high byte latches the y low byte for the later low read.
// - reading the z high byte latches the z low byte for the later low read.
// - address 0x0c returns the latched temperature low byte, read after the high byte.
// - reading temperature high at address 0x0d latches the temperature low byte.
// - the assembled acceleration is two's complement with zero reading as all zeros.
// - during reset or under-voltage every register reads zero.
`timescale 1ns/100ps
`include "acr_consts.svh"
module acr_regbank #(
  // arbitrary value, one per silicon version
  parameter logic [7:0] REV_NUMBER = 8'h01
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // serial pins
  input  wire logic                   i_sck,
  input  wire logic                   i_csb_n,
  input  wire logic                   i_mosi,
  output logic                        o_miso,
  output logic                        o_miso_oe,
  // sensor core, same clock
  input  wire logic [`ACR_SMP_W-1:0]  i_x_sample,
  input  wire logic [`ACR_SMP_W-1:0]  i_y_sample,
  input  wire logic [`ACR_SMP_W-1:0]  i_z_sample,
  input  wire logic [15:0]            i_temp_sample,
  input  wire logic                   i_analog_test,
  input  wire logic                   i_checksum_bad,
  // supply monitor pin
  input  wire logic                   i_undervolt,
  // state towards the core
  output logic [7:0]                  o_control_settings,
  output logic                        o_sw_reset,
  output logic                        o_frame_error_flag,
  output logic                        o_selftest_fail_flag
);

  function automatic logic [7:0] lo_byte(input logic [`ACR_SMP_W-1:0] s);
    lo_byte = {s[`ACR_SMP_LO], 1'b0};
  endfunction

  function automatic logic [7:0] hi_byte(input logic [`ACR_SMP_W-1:0] s);
    hi_byte = {2'b00, s[`ACR_SMP_HI]};
  endfunction

  logic [3:0] sync_w;
  logic       sck_s;
  logic       csb_s;
  logic       mosi_s;
  logic       uv_s;

  acr_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h4)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_sck, i_csb_n, i_mosi, i_undervolt}),
    .o_sync  (sync_w)
  );

  assign sck_s  = sync_w[3];
  assign csb_s  = sync_w[2];
  assign mosi_s = sync_w[1];
  assign uv_s   = sync_w[0];

  // serial engine state
  logic        sck_p_q, sck_p_d;
  logic        csb_p_q, csb_p_d;
  logic        act_q, act_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [7:0]  tx_q, tx_d;
  logic [7:0]  rdata_q, rdata_d;

  // register state
  logic [7:0]       ctrl_q, ctrl_d;
  logic [7:0]       key_q, key_d;
  acr_pkg::acr_key_t key_st_q, key_st_d;
  logic [7:0]       xl_q, xl_d;
  logic [7:0]       yl_q, yl_d;
  logic [7:0]       zl_q, zl_d;
  logic [7:0]       tl_q, tl_d;
  logic             frame_error_flag_q, frame_error_flag_d;
  logic             csum_q, csum_d;
  logic             swr_q, swr_d;

  logic        rise, fall, cs_fall, cs_rise;
  logic        addr_done, frame_ok, frame_bad, wr_en;
  logic [7:0]  addr_byte;
  logic [5:0]  addr_now;
  logic [5:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_byte;
  logic [7:0]  status_byte;

  assign rise      = sck_s & ~sck_p_q;
  assign fall      = ~sck_s & sck_p_q;
  assign cs_fall   = ~csb_s & csb_p_q;
  assign cs_rise   = csb_s & ~csb_p_q;
  assign addr_byte = {rx_q[6:0], mosi_s};
  assign addr_now  = addr_byte[`ACR_AB_ADDR];
  assign addr_done = act_q & rise & (cnt_q == `ACR_ADDR_LAST);
  // only a whole 16-clock frame counts; anything else is refused
  assign frame_ok  = act_q & cs_rise & (cnt_q == `ACR_FRAME_BITS);
  assign frame_bad = act_q & cs_rise & (cnt_q != `ACR_FRAME_BITS);
  assign wr_en     = frame_ok & rx_q[`ACR_RX_WR];
  assign wr_addr   = rx_q[`ACR_RX_ADDR];
  assign wr_data   = rx_q[`ACR_RX_DATA];

  always_comb begin
    status_byte               = `ACR_BYTE_RST;
    status_byte[`ACR_FR_ONE]  = 1'b1;
    status_byte[`ACR_FR_FRAME_ERROR_FLAG] = frame_error_flag_q;
    status_byte[`ACR_FR_ST]   = csum_q;
  end

  // read multiplexer; high bytes read live, low bytes read the latch
  always_comb begin
    case (addr_now)
      `ACR_ADDR_REV:  rd_byte = REV_NUMBER;
      `ACR_ADDR_CTRL: rd_byte = ctrl_q;
      `ACR_ADDR_STAT: rd_byte = {5'h00, i_analog_test, csum_q, frame_error_flag_q};
      `ACR_ADDR_KEY:  rd_byte = key_q;
      `ACR_ADDR_XL:   rd_byte = xl_q;
      `ACR_ADDR_XH:   rd_byte = hi_byte(i_x_sample);
      `ACR_ADDR_YL:   rd_byte = yl_q;
      `ACR_ADDR_YH:   rd_byte = hi_byte(i_y_sample);
      `ACR_ADDR_ZL:   rd_byte = zl_q;
      `ACR_ADDR_ZH:   rd_byte = hi_byte(i_z_sample);
      `ACR_ADDR_TL:   rd_byte = tl_q;
      `ACR_ADDR_TH:   rd_byte = i_temp_sample[`ACR_TEMP_HI];
      default:        rd_byte = `ACR_BYTE_RST;
    endcase
    if (uv_s) begin
      rd_byte = `ACR_BYTE_RST;
    end
  end

  // serial engine: mode 0, sample on rise, shift on fall
  always_comb begin
    sck_p_d = sck_s;
    csb_p_d = csb_s;
    act_d   = act_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    rdata_d = rdata_q;
    if (cs_fall) begin
      act_d = 1'b1;
      cnt_d = `ACR_CNT_RST;
      rx_d  = 16'h0000;
      tx_d  = status_byte;
    end else if (cs_rise) begin
      act_d = 1'b0;
    end else if (act_q) begin
      if (rise) begin
        rx_d = {rx_q[14:0], mosi_s};
        if (cnt_q != `ACR_CNT_MAX) begin
          cnt_d = cnt_q + `ACR_CNT_ONE;
        end
      end
      if (addr_done) begin
        rdata_d = rd_byte;
      end
      // data byte replaces the status byte at the eighth falling edge
      if (fall) begin
        if (cnt_q == `ACR_DATA_FIRST) begin
          tx_d = rdata_q;
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_p_q <= 1'b0;
      csb_p_q <= 1'b1;
      act_q   <= 1'b0;
      cnt_q   <= `ACR_CNT_RST;
      rx_q    <= 16'h0000;
      tx_q    <= `ACR_BYTE_RST;
      rdata_q <= `ACR_BYTE_RST;
    end else begin
      sck_p_q <= sck_p_d;
      csb_p_q <= csb_p_d;
      act_q   <= act_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      rdata_q <= rdata_d;
    end
  end

  // register bank
  always_comb begin
    ctrl_d   = ctrl_q;
    key_d    = key_q;
    key_st_d = key_st_q;
    xl_d     = xl_q;
    yl_d     = yl_q;
    zl_d     = zl_q;
    tl_d     = tl_q;
    swr_d    = 1'b0;
    csum_d   = i_checksum_bad;
    frame_error_flag_d   = frame_error_flag_q;
    if (frame_bad) begin
      frame_error_flag_d = 1'b1;
    end else if (frame_ok) begin
      frame_error_flag_d = 1'b0;
    end
    // read of a high byte freezes its low byte
    if (addr_done && !addr_byte[`ACR_AB_WR]) begin
      case (addr_now)
        `ACR_ADDR_XH: xl_d = lo_byte(i_x_sample);
        `ACR_ADDR_YH: yl_d = lo_byte(i_y_sample);
        `ACR_ADDR_ZH: zl_d = lo_byte(i_z_sample);
        `ACR_ADDR_TH: tl_d = i_temp_sample[`ACR_TEMP_LO];
        default:      tl_d = tl_q;
      endcase
    end
    // only two addresses accept data; others drop the write
    if (wr_en && wr_addr == `ACR_ADDR_CTRL) begin
      ctrl_d = wr_data;
    end
    if (wr_en && wr_addr == `ACR_ADDR_KEY) begin
      key_d = wr_data;
      case (key_st_q)
        acr_pkg::ACR_KEY_IDLE: begin
          key_st_d = (wr_data == `ACR_KEY_1) ? acr_pkg::ACR_KEY_GOT1
                                             : acr_pkg::ACR_KEY_IDLE;
        end
        acr_pkg::ACR_KEY_GOT1: begin
          if (wr_data == `ACR_KEY_2) begin
            key_st_d = acr_pkg::ACR_KEY_GOT2;
          end else if (wr_data == `ACR_KEY_1) begin
            key_st_d = acr_pkg::ACR_KEY_GOT1;
          end else begin
            key_st_d = acr_pkg::ACR_KEY_IDLE;
          end
        end
        acr_pkg::ACR_KEY_GOT2: begin
          if (wr_data == `ACR_KEY_3) begin
            key_st_d = acr_pkg::ACR_KEY_IDLE;
            swr_d    = 1'b1;
          end else if (wr_data == `ACR_KEY_1) begin
            key_st_d = acr_pkg::ACR_KEY_GOT1;
          end else begin
            key_st_d = acr_pkg::ACR_KEY_IDLE;
          end
        end
        default: key_st_d = acr_pkg::ACR_KEY_IDLE;
      endcase
    end
    // software reset and under-voltage both wipe the bank except the frame error and checksum flags
    if (swr_d || uv_s) begin
      ctrl_d   = `ACR_BYTE_RST;
      key_d    = `ACR_BYTE_RST;
      key_st_d = acr_pkg::ACR_KEY_IDLE;
      xl_d     = `ACR_BYTE_RST;
      yl_d     = `ACR_BYTE_RST;
      zl_d     = `ACR_BYTE_RST;
      tl_d     = `ACR_BYTE_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q   <= `ACR_BYTE_RST;
      key_q    <= `ACR_BYTE_RST;
      key_st_q <= acr_pkg::ACR_KEY_IDLE;
      xl_q     <= `ACR_BYTE_RST;
      yl_q     <= `ACR_BYTE_RST;
      zl_q     <= `ACR_BYTE_RST;
      tl_q     <= `ACR_BYTE_RST;
      frame_error_flag_q   <= 1'b0;
      csum_q   <= 1'b0;
      swr_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      key_q    <= key_d;
      key_st_q <= key_st_d;
      xl_q     <= xl_d;
      yl_q     <= yl_d;
      zl_q     <= zl_d;
      tl_q     <= tl_d;
      frame_error_flag_q   <= frame_error_flag_d;
      csum_q   <= csum_d;
      swr_q    <= swr_d;
    end
  end

  // pins; miso lags sck by the synchroniser, fine at slow sck
  assign o_miso               = tx_q[7];
  assign o_miso_oe            = act_q;
  assign o_control_settings   = ctrl_q;
  assign o_sw_reset           = swr_q;
  assign o_frame_error_flag   = frame_error_flag_q;
  assign o_selftest_fail_flag = csum_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_read(logic [5:0] a);
    addr_done && !addr_byte[`ACR_AB_WR] && addr_now == a && !uv_s;
  endsequence

  sequence s_key_last;
    wr_en && wr_addr == `ACR_ADDR_KEY && wr_data == `ACR_KEY_3 &&
      key_st_q == acr_pkg::ACR_KEY_GOT2 && !uv_s;
  endsequence

  property p_rev;
    s_read(`ACR_ADDR_REV) |=> rdata_q == REV_NUMBER;
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision read wrong");

  property p_ctrl;
    wr_en && wr_addr == `ACR_ADDR_CTRL && !uv_s |=>
      o_control_settings == $past(wr_data);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control write lost");

  property p_stat;
    s_read(`ACR_ADDR_STAT) |=>
      rdata_q[7:3] == 5'h00 && rdata_q[2] == $past(i_analog_test);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read wrong");

  property p_st;
    i_checksum_bad ##1 cs_fall |=> tx_q[`ACR_FR_ST];
  endproperty
  a_st: assert property (p_st)
    else $error("self-test bit missing");

  // the response after a flagged frame must carry the flag to the host
  property p_frame_error_flag;
    o_frame_error_flag && cs_fall |=> tx_q[`ACR_FR_FRAME_ERROR_FLAG];
  endproperty
  a_frame_error_flag: assert property (p_frame_error_flag)
    else $error("frame error not sent");

  property p_frame_error_flag_clr;
    frame_ok |=> !o_frame_error_flag;
  endproperty
  a_frame_error_flag_clr: assert property (p_frame_error_flag_clr)
    else $error("frame error not cleared");

  property p_frame_error_flag_set;
    frame_bad |=> o_frame_error_flag;
  endproperty
  a_frame_error_flag_set: assert property (p_frame_error_flag_set)
    else $error("frame error not set");

  property p_key;
    s_key_last |=> (o_sw_reset && o_control_settings == 8'h00) ##1
      !o_sw_reset;
  endproperty
  a_key: assert property (p_key)
    else $error("key sequence did not reset");

  property p_xh;
    s_read(`ACR_ADDR_XH) |=> rdata_q[7:6] == 2'b00 &&
      rdata_q[5:0] == $past(i_x_sample[`ACR_SMP_HI]) &&
      xl_q == {$past(i_x_sample[`ACR_SMP_LO]), 1'b0};
  endproperty
  a_xh: assert property (p_xh)
    else $error("x latch wrong");

  property p_yh;
    s_read(`ACR_ADDR_YH) |=> yl_q == {$past(i_y_sample[`ACR_SMP_LO]), 1'b0};
  endproperty
  a_yh: assert property (p_yh)
    else $error("y latch wrong");

  property p_zh;
    s_read(`ACR_ADDR_ZH) |=> zl_q == {$past(i_z_sample[`ACR_SMP_LO]), 1'b0};
  endproperty
  a_zh: assert property (p_zh)
    else $error("z latch wrong");

  property p_th;
    s_read(`ACR_ADDR_TH) |=> rdata_q == $past(i_temp_sample[`ACR_TEMP_HI]);
  endproperty
  a_th: assert property (p_th)
    else $error("temperature high read wrong");

  property p_tl;
    s_read(`ACR_ADDR_TH) |=> tl_q == $past(i_temp_sample[`ACR_TEMP_LO]);
  endproperty
  a_tl: assert property (p_tl)
    else $error("temperature latch wrong");

  property p_uv;
    uv_s |-> rd_byte == 8'h00 ##1 (o_control_settings == 8'h00 &&
      xl_q == 8'h00 && tl_q == 8'h00);
  endproperty
  a_uv: assert property (p_uv)
    else $error("register not zero in under-voltage");

  property p_ro;
    wr_en && wr_addr != `ACR_ADDR_CTRL && wr_addr != `ACR_ADDR_KEY && !uv_s
      |=> $stable(o_control_settings) && $stable(xl_q) && $stable(tl_q);
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only write took effect");

endmodule

// File: bench/acr_host_model.sv
`timescale 1ns/100ps
module acr_host_model (
  // clock
  input  wire logic i_mclk,
  // serial pins
  output logic      o_sck,
  output logic      o_csb_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial begin
    o_sck   = 1'b0;
    o_csb_n = 1'b1;
    o_mosi  = 1'b0;
  end

  // mode 0 master, 8 mclk per sck period; n < 16 makes a broken frame.
  // miso is taken late in the high phase, well after the device moves it
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge i_mclk);
    o_csb_n <= 1'b0;
    o_mosi  <= w[15];
    repeat (8) @(posedge i_mclk);
    for (int i = 0; i < n; i++) begin
      o_sck <= 1'b1;
      repeat (4) @(posedge i_mclk);
      r = {r[14:0], i_miso};
      o_sck <= 1'b0;
      if (i < 15) o_mosi <= w[14-i];
      repeat (4) @(posedge i_mclk);
    end
    // released line shows the inverse, so a stale bit never looks valid
    o_csb_n <= 1'b1;
    o_mosi  <= ~o_mosi;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// File: bench/tb_acr_regbank.sv
`timescale 1ns/100ps
`include "acr_consts.svh"
module tb_acr_regbank;
  // arbitrary value
  localparam logic [7:0] REV = 8'h5a;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sck, csb_n, mosi, miso, miso_oe;
  logic [12:0] xs = 13'h0000, ys = 13'h0000, zs = 13'h0000;
  logic [15:0] ts = 16'h0000;
  logic        analog_test_active = 1'b0, csum = 1'b0, uv = 1'b0;
  logic [7:0]  ctrl;
  logic        swr, fe, st;
  logic [7:0]  stat_b;
  int          fail_count = 0;
  int          checks_done = 0;
  int          pulses = 0;

  always #12.5 mclk = ~mclk;
  always @(negedge mclk) if (swr === 1'b1) pulses++;

  acr_regbank #(.REV_NUMBER(REV)) u_acr_regbank (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_sck(sck), .i_csb_n(csb_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
    .i_x_sample(xs), .i_y_sample(ys), .i_z_sample(zs),
    .i_temp_sample(ts), .i_analog_test(analog_test_active), .i_checksum_bad(csum),
    .i_undervolt(uv), .o_control_settings(ctrl), .o_sw_reset(swr),
    .o_frame_error_flag(fe), .o_selftest_fail_flag(st));
  acr_host_model u_acr_host_model (
    .i_mclk(mclk), .o_sck(sck), .o_csb_n(csb_n), .o_mosi(mosi),
    .i_miso(miso));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    u_acr_host_model.xfer({a, 1'b1, ~^{a, 1'b1}, d}, 16, r);
    stat_b = r[15:8];
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    logic [15:0] r;
    u_acr_host_model.xfer({a, 1'b0, ~^{a, 1'b0}, 8'h00}, 16, r);
    stat_b = r[15:8];
    d = r[7:0];
  endtask

  task automatic t_reset();
    check({miso_oe, swr, fe, st, ctrl}, 16'h0000);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check({miso_oe, swr, fe, st, ctrl}, 16'h0000);
  endtask

  task automatic t_rev_ctrl();
    logic [7:0] d;
    wr(`ACR_ADDR_REV, 8'hff);
    rd(`ACR_ADDR_REV, d);
    check(d, REV);
    check(stat_b, 8'h80);
    wr(`ACR_ADDR_CTRL, 8'ha5);
    rd(`ACR_ADDR_CTRL, d);
    check(d, 8'ha5);
    check(ctrl, 8'ha5);
  endtask

  task automatic t_status();
    logic [7:0] d;
    @(posedge mclk);
    analog_test_active <= 1'b1;
    csum  <= 1'b1;
    wr(`ACR_ADDR_STAT, 8'hff);
    rd(`ACR_ADDR_STAT, d);
    check(d, 8'h06);
    check(stat_b, 8'h82);
    check(st, 1'b1);
    analog_test_active <= 1'b0;
    csum  <= 1'b0;
    rd(`ACR_ADDR_STAT, d);
    check(d, 8'h00);
    check(stat_b, 8'h80);
  endtask

  task automatic t_frame_err();
    logic [15:0] r;
    logic [7:0]  d;
    // short frame carrying a write that must be dropped
    u_acr_host_model.xfer({`ACR_ADDR_CTRL, 2'b10, 8'h33}, 12, r);
    check(fe, 1'b1);
    rd(`ACR_ADDR_STAT, d);
    check(d, 8'h01);
    check(stat_b, 8'h84);
    check(fe, 1'b0);
    rd(`ACR_ADDR_CTRL, d);
    check(d, 8'ha5);
  endtask

  task automatic set_axis(input int k, input logic [12:0] v);
    @(posedge mclk);
    case (k)
      0: xs <= v;
      1: ys <= v;
      default: zs <= v;
    endcase
  endtask

  task automatic t_axes();
    logic [7:0]  d;
    logic [12:0] a;
    logic [5:0]  hi;
    for (int k = 0; k < 3; k++) begin
      a  = 13'h1abc - 13'(k * 13'h0123);
      hi = 6'(`ACR_ADDR_XH + 6'(2 * k));
      set_axis(k, a);
      rd(hi, d);
      check(d, {2'b00, a[12:7]});
      set_axis(k, 13'h0000);
      rd(hi - 6'h01, d);
      check(d, {a[6:0], 1'b0});
      rd(hi, d);
      check(d, 8'h00);
      rd(hi - 6'h01, d);
      check(d, 8'h00);
    end
  endtask

  task automatic t_temp();
    logic [7:0] d;
    @(posedge mclk);
    ts <= 16'hc37e;
    rd(`ACR_ADDR_TH, d);
    check(d, 8'hc3);
    ts <= 16'h0000;
    rd(`ACR_ADDR_TL, d);
    check(d, 8'h7e);
  endtask

  task automatic t_key();
    logic [7:0] d;
    wr(`ACR_ADDR_CTRL, 8'h3c);
    pulses = 0;
    // wrong order must not fire the reset
    wr(`ACR_ADDR_KEY, `ACR_KEY_1);
    wr(`ACR_ADDR_KEY, `ACR_KEY_3);
    wr(`ACR_ADDR_KEY, `ACR_KEY_2);
    wr(`ACR_ADDR_KEY, `ACR_KEY_3);
    rd(`ACR_ADDR_KEY, d);
    check(d, `ACR_KEY_3);
    check(16'(pulses), 16'h0000);
    wr(`ACR_ADDR_KEY, `ACR_KEY_1);
    wr(`ACR_ADDR_KEY, `ACR_KEY_2);
    wr(`ACR_ADDR_KEY, `ACR_KEY_3);
    check(16'(pulses), 16'h0001);
    check(ctrl, 8'h00);
  endtask

  task automatic t_undervolt();
    logic [7:0] d;
    wr(`ACR_ADDR_CTRL, 8'h5a);
    uv <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`ACR_ADDR_REV, d);
    check(d, 8'h00);
    rd(`ACR_ADDR_CTRL, d);
    check(d, 8'h00);
    uv <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(`ACR_ADDR_CTRL, d);
    check(d, 8'h00);
  endtask

  // cuts a hang short; every wait below is a fixed count
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge mclk);
    t_reset();
    t_rev_ctrl();
    t_status();
    t_frame_err();
    t_axes();
    t_temp();
    t_key();
    t_undervolt();
    complete_run();
  end
endmodule
